// File: shared/pipm_pkg.sv
// Constants and types shared by the pin interrupt / pattern match block.
// Assumes a single clock domain and pins already routed in by the pad ring.
//
// Notes on behaviour
// - Eight software-selected pins, edge or level.
// - One separate request line per channel.
// - Edge channels flag rising, falling or both.
// - Level channels active high or low.
// - Pin requests also raise a wake request.
// - Pattern match uses eight selected inputs.
// - Term conditions are levels or transitions.
// - Each product term has its own request.
// - Optional one-cycle event when the combined match rises.
// - Event notification is a routable output.
// - Pattern matches never raise wake requests.
// - Pin choice independent of pin function.
// - Combined match result drives an output.
`default_nettype none

package pipm_pkg;

  // Channel count and pin count defaults
  localparam int NUM_CHANNELS  = 8;
  localparam int DEF_PIN_COUNT = 32;
  // Width of the channel index inside a slice
  localparam int SRC_W         = 3;
  // Synchroniser depth in front of every channel
  localparam int SYNC_STAGES   = 2;

  // Slice condition codes
  typedef enum logic [2:0] {
    PIPM_COND_ALWAYS = 3'h0,  // Slice always true
    PIPM_COND_HIGH   = 3'h1,  // Input is high
    PIPM_COND_LOW    = 3'h2,  // Input is low
    PIPM_COND_RISE   = 3'h3,  // Rising transition this cycle
    PIPM_COND_FALL   = 3'h4,  // Falling transition this cycle
    PIPM_COND_EITHER = 3'h5,  // Any transition this cycle
    PIPM_COND_NEVER  = 3'h6   // Slice always false
  } pipm_cond_t;

  // Per-channel pin interrupt configuration
  typedef struct packed {
    logic levelMode;   // 1 level, 0 edge
    logic riseEn;      // Edge mode: flag rising edges
    logic fallEn;      // Edge mode: flag falling edges
    logic activeHigh;  // Level mode: polarity
  } pipm_chan_cfg_t;

  // Per-slice pattern match configuration
  typedef struct packed {
    logic [SRC_W-1:0] srcChan;   // Which synchronised channel
    pipm_cond_t       cond;      // Condition on it
    logic             endPoint;  // Last slice of a product term
  } pipm_slice_cfg_t;

  // Reset values
  localparam pipm_chan_cfg_t  CHAN_CFG_RST  = '0;
  localparam logic            MODE_RST      = 1'b0;

endpackage : pipm_pkg

`default_nettype wire

// File: design/pipm_sync.sv
// Two-flop level synchroniser for one pin.
// Assumes the input may be asynchronous to ref_clk.
`default_nettype none

module pipm_sync
  import pipm_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic asyncIn,
  output var  logic syncOut
);

  ////////////////////////////////////////////////////////////////////
  logic meta_r;  // First stage, read only by the second

  // Both stages clear on reset; the first is looked at by nothing else
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      meta_r  <= 1'b0;
      syncOut <= 1'b0;
    end
    else
    begin
      meta_r  <= asyncIn;
      syncOut <= meta_r;
    end
  end

endmodule : pipm_sync

`default_nettype wire

// File: design/pipm_top.sv
// Pin interrupt and pattern match engine, top level.
// Assumes pins arrive already routed from any pad; config bits are static
// between changes and driven by the system configuration logic.
`default_nettype none

module pipm_top
  import pipm_pkg::*;
#(
  parameter int CHANNELS  = NUM_CHANNELS,
  parameter int PIN_COUNT = DEF_PIN_COUNT
)
(
  input  wire logic                                  ref_clk,
  input  wire logic                                  rst,
  input  wire logic [PIN_COUNT-1:0]                  pinBus,
  input  wire logic [$clog2(PIN_COUNT)-1:0]          pinSel [CHANNELS],
  input  wire logic                                  matchModeEn,
  input  wire pipm_chan_cfg_t [CHANNELS-1:0]         chanCfg,
  input  wire pipm_slice_cfg_t [CHANNELS-1:0]        sliceCfg,
  input  wire logic                                  eventEn,
  input  wire logic [CHANNELS-1:0]                   edgeClr,
  output var  logic [CHANNELS-1:0]                   irqReq,
  output var  logic                                  wakeReq,
  output var  logic                                  cpuEventNotify,
  output var  logic                                  patternMatchOut
);


  ////////////////////////////////////////////////////////////////////
  // Elaboration checks
  if (CHANNELS < 1 || CHANNELS > (1 << SRC_W))
  begin : g_bad_ch
    $error("CHANNELS must be 1 to 8");
  end
  if (PIN_COUNT < 2)
  begin : g_bad_pins
    $error("PIN_COUNT must be at least 2");
  end

  ////////////////////////////////////////////////////////////////////
  // Pin selection and synchronisers
  logic [CHANNELS-1:0] selPin;   // Raw selected pin per channel
  logic [CHANNELS-1:0] chanLvl;  // Synchronised level
  logic [CHANNELS-1:0] prev_r;   // Level one cycle earlier
  logic [CHANNELS-1:0] riseEv;   // Rising transition this cycle
  logic [CHANNELS-1:0] fallEv;   // Falling transition this cycle

  for (genvar i = 0; i < CHANNELS; i++)
  begin : g_chan
    // Taps the pin itself, so its peripheral owner does not matter
    assign selPin[i] = (32'(pinSel[i]) < PIN_COUNT) ? pinBus[pinSel[i]] : 1'b0;

    pipm_sync u_sync
    (
      .ref_clk (ref_clk),
      .rst     (rst),
      .asyncIn (selPin[i]),
      .syncOut (chanLvl[i])
    );
  end

  // History for transition detection, only on synchronised levels
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      prev_r <= '0;
    else
      prev_r <= chanLvl;
  end

  assign riseEv = chanLvl & ~prev_r;
  assign fallEv = ~chanLvl & prev_r;

  ////////////////////////////////////////////////////////////////////
  // Pin interrupt channels
  logic [CHANNELS-1:0] edgeFlag_r;    // Sticky edge flags
  logic [CHANNELS-1:0] edgeFlag_nxt;  // Next sticky value
  logic [CHANNELS-1:0] chanReq;       // Per-channel request

  // Set beats clear so an edge in the clear cycle survives
  always_comb
  begin
    for (int i = 0; i < CHANNELS; i++)
    begin
      edgeFlag_nxt[i] = (edgeFlag_r[i] & ~edgeClr[i])
                      | (~chanCfg[i].levelMode
                         & ((chanCfg[i].riseEn & riseEv[i])
                          | (chanCfg[i].fallEn & fallEv[i])));
      if (chanCfg[i].levelMode)
        chanReq[i] = (chanLvl[i] == chanCfg[i].activeHigh);
      else
        chanReq[i] = edgeFlag_nxt[i];
    end
  end

  // Flags are only kept in pin interrupt mode
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      edgeFlag_r <= '0;
    else if (matchModeEn)
      edgeFlag_r <= '0;
    else
      edgeFlag_r <= edgeFlag_nxt;
  end

  ////////////////////////////////////////////////////////////////////
  // Pattern match slices
  logic [CHANNELS-1:0] sliceHit;  // Slice condition true
  logic [CHANNELS-1:0] termHit;   // Product term ending here true
  logic                termAny;   // Any term true

  // Terms run from the slice after one endpoint to the next;
  // the last slice always closes a term so none is left open
  always_comb
  begin
    logic acc;
    acc = 1'b1;
    for (int i = 0; i < CHANNELS; i++)
    begin
      unique case (sliceCfg[i].cond)
        PIPM_COND_ALWAYS: sliceHit[i] = 1'b1;
        PIPM_COND_HIGH:   sliceHit[i] = chanLvl[sliceCfg[i].srcChan];
        PIPM_COND_LOW:    sliceHit[i] = ~chanLvl[sliceCfg[i].srcChan];
        PIPM_COND_RISE:   sliceHit[i] = riseEv[sliceCfg[i].srcChan];
        PIPM_COND_FALL:   sliceHit[i] = fallEv[sliceCfg[i].srcChan];
        PIPM_COND_EITHER: sliceHit[i] = riseEv[sliceCfg[i].srcChan] | fallEv[sliceCfg[i].srcChan];
        PIPM_COND_NEVER:  sliceHit[i] = 1'b0;
        default:          sliceHit[i] = 1'b0;  // Unused code 7
      endcase
      acc = acc & sliceHit[i];
      termHit[i] = (sliceCfg[i].endPoint || i == CHANNELS - 1) && acc;
      if (sliceCfg[i].endPoint)
        acc = 1'b1;
    end
    termAny = |termHit;
  end

  ////////////////////////////////////////////////////////////////////
  // Registered outputs
  // One line per channel, or per term in match mode
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      irqReq <= '0;
    else if (matchModeEn)
      irqReq <= termHit;
    else
      irqReq <= chanReq;
  end

  // Wake comes from pin channels only; detection needs no CPU clock path
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      wakeReq <= 1'b0;
    else
      wakeReq <= ~matchModeEn & (|chanReq);
  end

  // Combined match level, routable to a pin
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      patternMatchOut <= 1'b0;
    else
      patternMatchOut <= matchModeEn & termAny;
  end

  // One pulse per new match; a held match does not repeat the event
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      cpuEventNotify <= 1'b0;
    else
      cpuEventNotify <= eventEn & matchModeEn & termAny & ~patternMatchOut;
  end

  ////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  for (genvar i = 0; i < CHANNELS; i++)
  begin : g_chk
    a_edge_rise_req: assert property (
      !matchModeEn && !chanCfg[i].levelMode && chanCfg[i].riseEn && riseEv[i] |=> irqReq[i])
      else $error("rising edge not requested");
    a_edge_fall_req: assert property (
      !matchModeEn && !chanCfg[i].levelMode && chanCfg[i].fallEn && fallEv[i] |=> irqReq[i])
      else $error("falling edge not requested");
    // The held request must itself come from edge mode, else a term or level result looks like a flag
    a_edge_flag_hold: assert property (
      !matchModeEn && !chanCfg[i].levelMode
      ##1 !matchModeEn && !chanCfg[i].levelMode && irqReq[i] && !edgeClr[i] |=> irqReq[i])
      else $error("edge flag lost");
    a_level_req_track: assert property (
      !matchModeEn && chanCfg[i].levelMode |=> irqReq[i] == ($past(chanLvl[i]) == $past(chanCfg[i].activeHigh)))
      else $error("level request wrong");
    a_sync_two_stage: assert property (
      $stable(pinSel[i]) [*3] |-> chanLvl[i] == $past(selPin[i], 2))
      else $error("synchroniser depth wrong");
    a_term_irq_raise: assert property (
      matchModeEn && termHit[i] |=> irqReq[i])
      else $error("term request missing");
  end

  a_wake_pin_only: assert property (
    matchModeEn |=> !wakeReq)
    else $error("wake from pattern match");
  a_wake_from_req: assert property (
    !$past(matchModeEn) && irqReq != '0 |-> wakeReq)
    else $error("pin request without wake");
  a_event_one_pulse: assert property (
    cpuEventNotify |=> !cpuEventNotify)
    else $error("event longer than one cycle");
  a_event_on_match: assert property (
    cpuEventNotify |-> patternMatchOut && $past(eventEn) && !$past(patternMatchOut))
    else $error("event without new match");
  a_match_out_src: assert property (
    patternMatchOut |-> $past(matchModeEn) && $past(termAny))
    else $error("match output without term");

  c_edge_irq:  cover property (!matchModeEn && !chanCfg[0].levelMode ##1 irqReq[0]);
  c_level_irq: cover property (!matchModeEn && chanCfg[0].levelMode ##1 irqReq[0]);
  c_event:     cover property (cpuEventNotify);
  c_wake:      cover property (wakeReq);

endmodule : pipm_top

`default_nettype wire

// File: testbench/pipm_pin_model.sv
// Pin-side partner: the pad ring feeding the block's pin bus.
// Assumes the bench sets the eight watched pin levels at falling edges.
`default_nettype none

module pipm_pin_model
  import pipm_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic [7:0]  pinLvl,
  output var  logic [31:0] pinBus
);
  timeunit 1ns;
  timeprecision 1ps;

  // Pins owned by other functions keep moving, so stale levels never help
  logic [23:0] noise_r = 24'h00_5A5A;

  ////////////////////////////////////////////////////////////////////////////
  // Unwatched pins toggle every cycle
  always @(negedge ref_clk)
  begin
    noise_r <= ~noise_r;
  end

  // Watched pins sit in the low byte
  assign pinBus = {noise_r, pinLvl};
endmodule : pipm_pin_model

`default_nettype wire

// File: testbench/tb_pin_interrupt_pattern_match.sv
// Self-checking bench for the pin interrupt and pattern match block.
// Assumes the pin model above and a static configuration between tests.
`default_nettype none

module tb_pin_interrupt_pattern_match
  import pipm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // One row: channel setup, start level, end level, expected request
  typedef struct packed {
    pipm_chan_cfg_t cfg;
    logic           startLvl;
    logic           endLvl;
    logic           expIrq;
  } pipm_row_t;

  logic                   ref_clk = 1'b0;
  logic                   rst     = 1'b1;
  logic [7:0]             pinLvl  = 8'h00;   // Watched pin levels
  logic [31:0]            pinBus;
  logic [4:0]             pinSel [8];
  logic                   matchModeEn = 1'b0;
  pipm_chan_cfg_t [7:0]   chanCfg  = '0;
  pipm_slice_cfg_t [7:0]  sliceCfg = '0;
  logic                   eventEn = 1'b0;
  logic [7:0]             edgeClr = 8'h00;
  logic [7:0]             irqReq;
  logic                   wakeReq;
  logic                   cpuEventNotify;
  logic                   patternMatchOut;
  int                     n_errors  = 0;
  int                     tests_run = 0;
  int                     evCnt, wakeCnt, termCnt, andCnt, anyCnt;  // Pulse counters
  logic                   cntClr = 1'b0;  // Restarts the pulse counters
  pipm_row_t              rows [11] = '{7'h23, 7'h24, 7'h12, 7'h15, 7'h33, 7'h35,
                                        7'h02, 7'h4B, 7'h4C, 7'h45, 7'h42};

  // Reversed pin choice so a mapping slip shows
  always_comb
  begin
    for (int i = 0; i < 8; i++) pinSel[i] = 5'(7 - i);
  end

  ////////////////////////////////////////////////////////////////////////////
  pipm_pin_model pipm_pin_model_i (.ref_clk(ref_clk), .pinLvl(pinLvl), .pinBus(pinBus));

  pipm_top pipm_top_i (
    .ref_clk(ref_clk), .rst(rst), .pinBus(pinBus), .pinSel(pinSel),
    .matchModeEn(matchModeEn), .chanCfg(chanCfg), .sliceCfg(sliceCfg),
    .eventEn(eventEn), .edgeClr(edgeClr), .irqReq(irqReq), .wakeReq(wakeReq),
    .cpuEventNotify(cpuEventNotify), .patternMatchOut(patternMatchOut));

  // 100 MHz clock
  initial
  begin
    forever #5 ref_clk = ~ref_clk;
  end

  // Count pulses at each rising edge; one process owns the counters, cntClr restarts them
  always @(posedge ref_clk)
  begin
    if (cntClr)
    begin
      evCnt   <= 0;
      wakeCnt <= 0;
      termCnt <= 0;
      andCnt  <= 0;
      anyCnt  <= 0;
    end
    else
    begin
      evCnt   <= evCnt + int'(cpuEventNotify === 1'b1);
      wakeCnt <= wakeCnt + int'(wakeReq === 1'b1);
      termCnt <= termCnt + int'(irqReq[1] === 1'b1);
      andCnt  <= andCnt + int'(irqReq[2] === 1'b1);
      anyCnt  <= anyCnt + int'(irqReq[3] === 1'b1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  // Hang guard well beyond the few hundred cycles the tests need
  initial
  begin
    #50000;
    n_errors++;
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (2) @(negedge ref_clk);
    check("irq in reset", irqReq, 8'h00);
    check("outs in reset", {5'h00, wakeReq, cpuEventNotify, patternMatchOut}, 8'h00);
    $display("test reset done");
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    // Pin mode table: every edge and level setup, both directions except edge with no enables
    foreach (rows[r])
    begin
      chanCfg = {8{rows[r].cfg}};
      pinLvl  = {8{rows[r].startLvl}};
      repeat (6) @(negedge ref_clk);
      edgeClr = 8'hFF;
      @(negedge ref_clk);
      edgeClr = 8'h00;
      repeat (3) @(negedge ref_clk);
      pinLvl = {8{rows[r].endLvl}};
      repeat (5) @(negedge ref_clk);
      check("irq row", irqReq, {8{rows[r].expIrq}});
      check("wake row", {7'h00, wakeReq}, {7'h00, rows[r].expIrq});
    end
    $display("test pin table done");
    // One pin high reaches only its own channel
    chanCfg = {8{4'h9}};
    pinLvl  = 8'h10;
    repeat (5) @(negedge ref_clk);
    check("irq lines", irqReq, 8'h08);
    $display("test distinct lines done");
    // Pattern match: level term on slice 0, transition term on slice 1
    pinLvl      = 8'h00;
    matchModeEn = 1'b1;
    eventEn     = 1'b1;
    sliceCfg    = {8{{3'h0, PIPM_COND_NEVER, 1'b1}}};
    sliceCfg[0] = {3'h3, PIPM_COND_HIGH, 1'b1};
    sliceCfg[1] = {3'h5, PIPM_COND_RISE, 1'b1};
    repeat (6) @(negedge ref_clk);
    cntClr = 1'b1;
    @(negedge ref_clk);
    cntClr = 1'b0;
    pinLvl = 8'h10;
    repeat (8) @(negedge ref_clk);
    check("term irq", irqReq, 8'h01);
    check("match out", {7'h00, patternMatchOut}, 8'h01);
    check("event count", 8'(evCnt), 8'h01);
    pinLvl = 8'h14;
    repeat (8) @(negedge ref_clk);
    check("rise term", 8'(termCnt), 8'h01);
    check("no wake", 8'(wakeCnt), 8'h00);
    $display("test pattern match done");
    // Mid-run reset with pins already high: cleared synchronisers see a rise
    matchModeEn = 1'b0;
    eventEn     = 1'b0;
    chanCfg     = {8{4'h4}};
    pinLvl      = 8'hFF;
    rst         = 1'b1;
    repeat (2) @(negedge ref_clk);
    check("irq mid reset", irqReq, 8'h00);
    check("outs mid reset", {5'h00, wakeReq, cpuEventNotify, patternMatchOut}, 8'h00);
    rst = 1'b0;
    repeat (2) @(negedge ref_clk);
    check("irq two edges", irqReq, 8'h00);
    repeat (2) @(negedge ref_clk);
    check("irq after release", irqReq, 8'hFF);
    check("wake after release", {7'h00, wakeReq}, 8'h01);
    $display("test mid-run reset done");
    // Clear alone drops the flags; a clear meeting a new edge loses
    pinLvl = 8'h00;
    repeat (3) @(negedge ref_clk);
    edgeClr = 8'hFF;
    @(negedge ref_clk);
    edgeClr = 8'h00;
    repeat (2) @(negedge ref_clk);
    check("irq cleared", irqReq, 8'h00);
    pinLvl = 8'hFF;
    repeat (2) @(negedge ref_clk);
    edgeClr = 8'hFF;
    @(negedge ref_clk);
    edgeClr = 8'h00;
    repeat (2) @(negedge ref_clk);
    check("set beats clear", irqReq, 8'hFF);
    $display("test edge clear done");
    // Match codes: three-slice AND ending at slice 2, any-edge on slice 3, event off
    matchModeEn = 1'b1;
    sliceCfg    = {8{{3'h0, PIPM_COND_NEVER, 1'b1}}};
    sliceCfg[0] = {3'h0, PIPM_COND_ALWAYS, 1'b0};
    sliceCfg[1] = {3'h1, PIPM_COND_LOW, 1'b0};
    sliceCfg[2] = {3'h2, PIPM_COND_FALL, 1'b1};
    sliceCfg[3] = {3'h3, PIPM_COND_EITHER, 1'b1};
    pinLvl      = 8'h70;
    repeat (6) @(negedge ref_clk);
    cntClr = 1'b1;
    @(negedge ref_clk);
    cntClr = 1'b0;
    // Channel 2 falls while channel 1 is high: no term
    pinLvl = 8'h50;
    repeat (6) @(negedge ref_clk);
    // Channel 3 falls: any-edge term, a new match with events off
    pinLvl = 8'h20;
    repeat (6) @(negedge ref_clk);
    // Channel 2 falls while channel 1 is low: AND term
    pinLvl = 8'h00;
    repeat (6) @(negedge ref_clk);
    check("and term", 8'(andCnt), 8'h01);
    check("either term", 8'(anyCnt), 8'h01);
    check("open slice", 8'(termCnt), 8'h00);
    check("terms idle", irqReq, 8'h00);
    check("match idle", {7'h00, patternMatchOut}, 8'h00);
    check("event off", 8'(evCnt), 8'h00);
    check("match no wake", 8'(wakeCnt), 8'h00);
    $display("test match codes done");
    tally_and_finish();
  end
endmodule : tb_pin_interrupt_pattern_match

`default_nettype wire
